// *** bench/rdct_timer_asserts.sv ***
// Purpose: Port-level checks for the reloading down-counter timer.
// Assumes: Classic Wishbone with an idle cycle between requests.
// Notes:   Bound to every rdct_timer instance.

`timescale 1ns/100ps

module rdct_timer_asserts
   import rdct_pkg::*;
#(
   parameter int unsigned DIV_CYCLES = rdct_pkg::DIV_CYCLES
)
(
   input wire logic                       clk_i,
   input wire logic                       rst_i,
   input wire logic                       wb_cyc_i,
   input wire logic                       wb_stb_i,
   input wire logic                       wb_we_i,
   input wire logic [rdct_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0]                 wb_sel_i,
   input wire logic [31:0]                wb_dat_i,
   input wire logic [31:0]                wb_dat_o,
   input wire logic                       wb_ack_o,
   input wire logic                       key_input_pin_i,
   input wire logic                       timer_irq_o,
   input wire logic                       shared_output_port_o,
   input wire logic                       shared_output_port_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   wire logic req      = wb_cyc_i & wb_stb_i;
   wire logic wr0      = wb_ack_o & wb_we_i & wb_sel_i[0];
   wire logic rd       = wb_ack_o & ~wb_we_i;
   wire logic cout_bit = wb_dat_i[3];

   // Mask shadow.
   // Tracks the mask as software last wrote it, so a request can be tied to it.
   logic mask_seen_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mask_seen_q <= 1'b0;
      else if (wr0 && wb_adr_i == {MASK_IDX, 2'b00})
         mask_seen_q <= wb_dat_i[MASK_BIT];
   end

   ////////////////////////////////////////////////////////////////////////
   a_ack_answers: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered after one cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   a_ack_caused: assert property (wb_ack_o |-> $past(req))
      else $error("acknowledge without request");
   a_strobe_reads_zero: assert property (rd && wb_adr_i == {CTRL_IDX, 2'b00}
      |-> wb_dat_o[31:1] == 31'h0)
      else $error("reload strobe read back as one");
   a_flag_narrow: assert property (rd && (wb_adr_i == {FLAG_IDX, 2'b00}
      || wb_adr_i == {MASK_IDX, 2'b00}) |-> wb_dat_o[31:1] == 31'h0)
      else $error("flag or mask upper bits set");
   a_mask_blocks_irq: assert property (wr0 && wb_adr_i == {MASK_IDX, 2'b00}
      && !wb_dat_i[0] |=> !timer_irq_o)
      else $error("interrupt forwarded while masked");
   a_irq_needs_mask: assert property (timer_irq_o |-> mask_seen_q)
      else $error("interrupt raised while mask clear");
   a_oe_follows_enable: assert property (wr0 && wb_adr_i == {CSEL_IDX, 2'b00}
      |=> shared_output_port_oe_o == $past(cout_bit))
      else $error("port enable does not follow clock output enable");
   a_port_gated: assert property (!shared_output_port_oe_o [*2] |-> !shared_output_port_o)
      else $error("port driven while output disabled");
   a_reset_clears: assert property ($fell(rst_i)
      |-> !wb_ack_o && !timer_irq_o && !shared_output_port_oe_o)
      else $error("outputs active after reset");
endmodule

bind rdct_timer rdct_timer_asserts #(.DIV_CYCLES(DIV_CYCLES)) i_rdct_timer_asserts (.clk_i,
   .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
   .wb_ack_o, .key_input_pin_i, .timer_irq_o, .shared_output_port_o, .shared_output_port_oe_o);

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for the reloading down-counter timer.
// Assumes: Prescaler cut to four clocks, so 8192 Hz is eight clocks.
// Notes:   Event periods are measured between interrupt rising edges.

`timescale 1ns/100ps

module tb_top;
   import rdct_pkg::*;
   logic             clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, key_input_pin_i;
   logic [ADR_W-1:0] wb_adr_i;
   logic [3:0]       wb_sel_i, q, h, sel_v;
   logic [31:0]      wb_dat_i, wb_dat_o;
   logic             wb_ack_o, timer_irq_o, shared_output_port_o, shared_output_port_oe_o;
   logic             irq_q, port_q;
   int               failures, total_checks, cyc_n, port_rises;
   int               rise_q[$];

   rdct_timer #(.DIV_CYCLES(4)) i_rdct_timer (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .key_input_pin_i, .timer_irq_o,
      .shared_output_port_o, .shared_output_port_oe_o);

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
   begin
      cyc_n++;
      if (timer_irq_o === 1'b1 && irq_q !== 1'b1)
         rise_q.push_back(cyc_n);
      if (shared_output_port_o === 1'b1 && port_q !== 1'b1)
         port_rises++;
      irq_q = timer_irq_o;
      port_q = shared_output_port_o;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Classic cycle held until ack is sampled; the ack edge takes the data.
   task automatic bus(input logic [11:0] idx, input logic we, input logic [3:0] d,
                      output logic [3:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= sel_v;
      wb_dat_i <= {28'h0, d};
      do
      begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      chk("bus ack", 1, {31'h0, wb_ack_o});
      rd = wb_dat_o[3:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] idx, input logic [3:0] d);
      bus(idx, 1'b1, d, q);
   endtask

   task automatic rdchk(input string what, input logic [11:0] idx, input logic [3:0] exp);
      bus(idx, 1'b0, 4'h0, q);
      chk(what, {28'h0, exp}, {28'h0, q});
   endtask

   task automatic wait_rise(input int limit, output int t);
      int n;
      n = 0;
      while (rise_q.size() == 0 && n < limit)
      begin
         @(posedge clk_i);
         n++;
      end
      chk("interrupt rise", 1, rise_q.size() > 0);
      t = (rise_q.size() > 0) ? rise_q.pop_front() : 0;
   endtask

   task automatic setup(input logic [3:0] csel, input int n, input logic mask);
      wr(CTRL_IDX, 4'h0);
      wr(CSEL_IDX, csel);
      wr(RLD_LO_IDX, n[3:0]);
      wr(RLD_HI_IDX, n[7:4]);
      wr(MASK_IDX, {3'h0, mask});
      wr(CTRL_IDX, 4'h2);
      bus(FLAG_IDX, 1'b0, 4'h0, q);
      rise_q.delete();
      wr(CTRL_IDX, 4'h1);
   endtask

   task automatic pulse(input int w);
      key_input_pin_i <= 1'b0;
      repeat (w) @(posedge clk_i);
      key_input_pin_i <= 1'b1;
      repeat (w) @(posedge clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      int v, c, s, n, p, t0, t1;
      {rst_i, key_input_pin_i} = 2'b11;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
      sel_v = 4'hF;
      void'($urandom(62304));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk("flag reset", FLAG_IDX, 4'h0);
      rdchk("mask reset", MASK_IDX, 4'h0);
      rdchk("control reset", CTRL_IDX, 4'h0);
      rdchk("select reset", CSEL_IDX, 4'h0);
      rdchk("unmapped", 12'hF30, 4'h0);
      v = 8'h40 + $urandom_range(191, 0);
      wr(CSEL_IDX, 4'h7);
      wr(RLD_LO_IDX, v[3:0]);
      wr(RLD_HI_IDX, v[7:4]);
      wr(CTRL_IDX, 4'h2);
      rdchk("count low", CNT_LO_IDX, v[3:0]);
      rdchk("count high", CNT_HI_IDX, v[7:4]);
      rdchk("strobe read", CTRL_IDX, 4'h0);
      wr(CNT_LO_IDX, ~v[3:0]);
      wr(FLAG_IDX, 4'h1);
      rdchk("count write", CNT_LO_IDX, v[3:0]);
      rdchk("flag write", FLAG_IDX, 4'h0);
      rdchk("reload high", RLD_HI_IDX, v[7:4]);
      // A write without its low byte lane selected must leave the reload value alone.
      sel_v = 4'hE;
      wr(RLD_LO_IDX, ~v[3:0]);
      sel_v = 4'hF;
      rdchk("reload lane", RLD_LO_IDX, v[3:0]);
      $display("test load done");
      wr(CTRL_IDX, 4'h1);
      repeat (50) @(posedge clk_i);
      wr(CTRL_IDX, 4'h0);
      bus(CNT_LO_IDX, 1'b0, 4'h0, q);
      bus(CNT_HI_IDX, 1'b0, 4'h0, h);
      c = {h, q};
      chk("count step", 1, (v - c) >= 4 && (v - c) <= 9);
      repeat (100) @(posedge clk_i);
      rdchk("stopped count", CNT_LO_IDX, c[3:0]);
      $display("test run stop done");
      for (s = 2; s <= 8; s++)
      begin
         n = (s == 8) ? 0 : $urandom_range(3, 1);
         c = (s == 8) ? 7 : s;
         p = (256 >> (c - 2)) * ((n == 0) ? 256 : n);
         setup(c[3:0], n, 1'b1);
         wait_rise(p + 900, t0);
         rdchk("event flag", FLAG_IDX, 4'h1);
         if (p >= 64) rdchk("flag cleared", FLAG_IDX, 4'h0);
         wait_rise(p + 900, t1);
         chk("event period", p, t1 - t0);
         $display("test period select %0d reload %0d done", c, n);
      end
      setup(4'h7, 2, 1'b0);
      repeat (60) @(posedge clk_i);
      rdchk("masked flag", FLAG_IDX, 4'h1);
      chk("masked interrupt", 0, rise_q.size());
      $display("test mask done");
      setup(4'h1, 3, 1'b1);
      pulse(10);
      pulse(10);
      rdchk("key early", FLAG_IDX, 4'h0);
      pulse(10);
      rdchk("key event", FLAG_IDX, 4'h1);
      setup(4'h0, 1, 1'b1);
      pulse(20);
      repeat (300) @(posedge clk_i);
      rdchk("short key", FLAG_IDX, 4'h0);
      pulse(600);
      rdchk("long key", FLAG_IDX, 4'h1);
      $display("test key done");
      wr(CSEL_IDX, 4'hF);
      // Skip the enable itself, which can look like one extra rise.
      repeat (16) @(negedge clk_i);
      t0 = port_rises;
      repeat (64) @(negedge clk_i);
      chk("port rises", 8, port_rises - t0);
      chk("port enable", 1, {31'h0, shared_output_port_oe_o});
      wr(CSEL_IDX, 4'h7);
      repeat (3) @(posedge clk_i);
      chk("port disable", 0, {31'h0, shared_output_port_oe_o});
      $display("test clock output done");
      test_done;
   end

   initial
   begin
      repeat (60000) @(posedge clk_i);
      failures++;
      $display("unexpected run length: expected below 60000 seen 60000");
      test_done;
   end
endmodule

// *** rtl/rdct_pkg.sv ***
// Purpose: Shared constants and types for the reloading down-counter timer.
// Assumes: 100 MHz system clock, classic Wishbone register access.
// Notes:   Register indices are word indices; the byte address is four times the index.

package rdct_pkg;

   //////////////////////////////////////////////////////////////////////////////
   // Clocking and prescaler.

   localparam int unsigned CLK_HZ     = 100_000_000;
   // The prescaler tick runs at twice the fastest count clock.
   localparam int unsigned TICK_HZ    = 16384;
   localparam int unsigned DIV_CYCLES = CLK_HZ / TICK_HZ;
   localparam int unsigned DIV_W      = 16;
   localparam int unsigned PRE_W      = 6;
   localparam int unsigned PRE_256_BIT = 5;

   //////////////////////////////////////////////////////////////////////////////
   // Register map.

   localparam int unsigned ADR_W = 14;
   localparam logic [11:0] FLAG_IDX   = 12'hF02;
   localparam logic [11:0] MASK_IDX   = 12'hF12;
   localparam logic [11:0] CNT_LO_IDX = 12'hF24;
   localparam logic [11:0] CNT_HI_IDX = 12'hF25;
   localparam logic [11:0] RLD_LO_IDX = 12'hF26;
   localparam logic [11:0] RLD_HI_IDX = 12'hF27;
   localparam logic [11:0] CTRL_IDX   = 12'hF78;
   localparam logic [11:0] CSEL_IDX   = 12'hF79;

   //////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values.

   localparam int unsigned FLAG_BIT   = 0;
   localparam int unsigned MASK_BIT   = 0;
   localparam int unsigned RUN_BIT    = 0;
   localparam int unsigned RELOAD_BIT = 1;
   localparam int unsigned SEL_LSB    = 0;
   localparam int unsigned COUT_BIT   = 3;
   localparam logic        FLAG_RST   = 1'b0;
   localparam logic        MASK_RST   = 1'b0;
   localparam logic        RUN_RST    = 1'b0;
   localparam logic        COUT_RST   = 1'b0;

   typedef enum logic [2:0] {
      SEL_KEY_FILT   = 3'h0,
      SEL_KEY_DIRECT = 3'h1,
      SEL_256        = 3'h2,
      SEL_512        = 3'h3,
      SEL_1024       = 3'h4,
      SEL_2048       = 3'h5,
      SEL_4096       = 3'h6,
      SEL_8192       = 3'h7
   } rdct_sel_t;

   localparam rdct_sel_t SEL_RST = SEL_KEY_FILT;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'h1,
      BUS_ACK  = 2'h2
   } rdct_bus_t;

endpackage

// *** rtl/rdct_timer.sv ***
// Purpose: Reloading 8-bit down-counter timer with a Wishbone register slave.
// Assumes: One 100 MHz clock, synchronous active-high reset, classic Wishbone.
// Notes:   Count and reload data are deliberately left without reset.
//
// Overview of operation
// - Eight-bit down-counter preset from a value software writes.
// - On reaching zero the counter reloads and keeps counting alone.
// - Decrement only on falling count-clock edges while running.
// - Three-bit select: filtered key, direct key, or 256 to 8192 Hz.
// - Filtered key mode samples at 512 Hz rejecting short chatter.
// - Event flag sets on reaching zero whatever the mask.
// - Interrupt request only while the mask bit is one; mask resets low.
// - Reload value is two writable nibbles, loaded on reload strobe and zero.
// - Reload value zero gives one event every 256 edges.
// - Reload value and count are not initialised by reset.
// - Writing one to the reload strobe loads the counter; reads zero.
// - A reload while running resumes at once; stopped it holds.
// - Run bit starts and stops counting, keeps count, resets low.
// - Live count readable as two read-only nibbles.
// - Clock output enable drives the selected count clock out.
// - Event flag resets low and ignores software writes.
//
// Local design decision: the Wishbone slave port.

`timescale 1ns/100ps

module rdct_timer
   import rdct_pkg::*;
#(
   parameter int unsigned DIV_CYCLES = rdct_pkg::DIV_CYCLES
)
(
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [rdct_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   input  wire logic                       key_input_pin_i,
   output logic                            timer_irq_o,
   output logic                            shared_output_port_o,
   output logic                            shared_output_port_oe_o
);

   import rdct_pkg::*;

   //////////////////////////////////////////////////////////////////////////////
   // Elaboration checks.

   generate
      if (DIV_CYCLES < 2 || DIV_CYCLES > 65535)
      begin : g_bad_div
         $error("DIV_CYCLES must lie between 2 and 65535");
      end
   endgenerate

   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CYCLES - 1);

   //////////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic [DIV_W-1:0] div_cnt_q;
   logic             tick_q;
   logic [PRE_W-1:0] pre_q;
   logic             key_s1_q;
   logic             key_s2_q;
   logic             key_s3_q;
   logic             key_level_q;
   logic             key_samp_q;
   logic             key_filt_q;
   logic             sel_level;
   logic             cclk_q;
   logic             cclk_fall;
   logic [7:0]       count_q;
   logic [7:0]       reload_q;
   logic             run_q;
   logic             mask_q;
   logic             flag_q;
   logic             cout_q;
   rdct_sel_t        sel_q;
   rdct_bus_t        bus_q;
   logic             req;
   logic             wr;
   logic             rd;
   logic [11:0]      idx;
   logic             wr_lo;
   logic             zero_evt;
   logic             reload_wr;
   logic [3:0]       rd_nib;

   //////////////////////////////////////////////////////////////////////////////
   // Prescaler: a tick enable and a binary chain of divided clocks.

   always_ff @(posedge clk_i)
   begin
      if (rst_i || div_cnt_q == DIV_LAST)
      begin
         div_cnt_q <= '0;
      end
      else
      begin
         div_cnt_q <= div_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= (div_cnt_q == DIV_LAST);
      end
   end

   // Bit 0 is the 8192 Hz clock, each higher bit halves it.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pre_q <= '0;
      end
      else if (tick_q)
      begin
         pre_q <= pre_q + 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Key input synchroniser and noise rejector.

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         key_s1_q <= 1'b0;
         key_s2_q <= 1'b0;
         key_s3_q <= 1'b0;
      end
      else
      begin
         key_s1_q <= key_input_pin_i;
         key_s2_q <= key_s1_q;
         key_s3_q <= key_s2_q;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         key_level_q <= 1'b0;
      end
      else if (key_s2_q == key_s3_q)
      begin
         key_level_q <= key_s3_q;
      end
   end

   // Sampling noise rejector.
   // Samples are taken on both edges of the 256 Hz clock and a level passes
   // only when two successive samples agree, so a spike seen once is lost.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         key_samp_q <= 1'b0;
         key_filt_q <= 1'b0;
      end
      else if (tick_q && pre_q[PRE_256_BIT-1:0] == '1)
      begin
         key_samp_q <= key_level_q;
         if (key_samp_q == key_level_q)
         begin
            key_filt_q <= key_level_q;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Count clock selection and falling edge detection.

   always_comb
   begin
      case (sel_q)
         SEL_KEY_FILT:   sel_level = key_filt_q;
         SEL_KEY_DIRECT: sel_level = key_level_q;
         SEL_256:        sel_level = pre_q[5];
         SEL_512:        sel_level = pre_q[4];
         SEL_1024:       sel_level = pre_q[3];
         SEL_2048:       sel_level = pre_q[2];
         SEL_4096:       sel_level = pre_q[1];
         default:        sel_level = pre_q[0];
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cclk_q <= 1'b0;
      end
      else
      begin
         cclk_q <= sel_level;
      end
   end

   assign cclk_fall = cclk_q & ~sel_level & run_q;

   //////////////////////////////////////////////////////////////////////////////
   // Wishbone slave: one wait state, ack for one cycle.

   assign req   = wb_cyc_i & wb_stb_i & (bus_q == BUS_IDLE);
   assign wr    = req & wb_we_i;
   assign rd    = req & ~wb_we_i;
   assign wr_lo = wr & wb_sel_i[0];
   assign idx   = wb_adr_i[ADR_W-1:2];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bus_q <= BUS_IDLE;
      end
      else
      begin
         case (bus_q)
            BUS_IDLE:
            begin
               if (req)
               begin
                  bus_q <= BUS_ACK;
               end
            end
            default:
            begin
               bus_q <= BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= req;
      end
   end

   always_comb
   begin
      rd_nib = 4'h0;
      if (idx == FLAG_IDX)
      begin
         rd_nib[FLAG_BIT] = flag_q;
      end
      else if (idx == MASK_IDX)
      begin
         rd_nib[MASK_BIT] = mask_q;
      end
      else if (idx == CNT_LO_IDX)
      begin
         rd_nib = count_q[3:0];
      end
      else if (idx == CNT_HI_IDX)
      begin
         rd_nib = count_q[7:4];
      end
      else if (idx == RLD_LO_IDX)
      begin
         rd_nib = reload_q[3:0];
      end
      else if (idx == RLD_HI_IDX)
      begin
         rd_nib = reload_q[7:4];
      end
      else if (idx == CTRL_IDX)
      begin
         rd_nib[RUN_BIT] = run_q;
      end
      else if (idx == CSEL_IDX)
      begin
         rd_nib[SEL_LSB +: 3] = sel_q;
         rd_nib[COUT_BIT]     = cout_q;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_dat_o <= 32'h0000_0000;
      end
      else if (rd)
      begin
         wb_dat_o <= {28'h000_0000, rd_nib};
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Control registers.

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         run_q <= RUN_RST;
      end
      else if (wr_lo && idx == CTRL_IDX)
      begin
         run_q <= wb_dat_i[RUN_BIT];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mask_q <= MASK_RST;
      end
      else if (wr_lo && idx == MASK_IDX)
      begin
         mask_q <= wb_dat_i[MASK_BIT];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sel_q  <= SEL_RST;
         cout_q <= COUT_RST;
      end
      else if (wr_lo && idx == CSEL_IDX)
      begin
         sel_q  <= rdct_sel_t'(wb_dat_i[SEL_LSB +: 3]);
         cout_q <= wb_dat_i[COUT_BIT];
      end
   end

   // No reset on the reload value.
   always_ff @(posedge clk_i)
   begin
      if (wr_lo && idx == RLD_LO_IDX)
      begin
         reload_q[3:0] <= wb_dat_i[3:0];
      end
      if (wr_lo && idx == RLD_HI_IDX)
      begin
         reload_q[7:4] <= wb_dat_i[3:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Down-counter.

   assign reload_wr = wr_lo && idx == CTRL_IDX && wb_dat_i[RELOAD_BIT];

   // Zero reached on this edge.
   // The zero state is replaced by the reload value in the same edge, so
   // software normally never reads zero unless the reload value is zero.
   assign zero_evt = cclk_fall && count_q == 8'h01;

   // A reload of zero wraps through all 256 states.
   // Reload strobe wins over a count edge in the same cycle.
   always_ff @(posedge clk_i)
   begin
      if (reload_wr || zero_evt)
      begin
         count_q <= reload_q;
      end
      else if (cclk_fall)
      begin
         count_q <= count_q - 8'h01;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Event flag and interrupt request.

   // Flag set on zero regardless of mask.
   // Flag resets low and ignores writes.
   // Read clears the flag; a new event in the same cycle wins.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         flag_q <= FLAG_RST;
      end
      else if (zero_evt)
      begin
         flag_q <= 1'b1;
      end
      else if (rd && idx == FLAG_IDX)
      begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         timer_irq_o <= 1'b0;
      end
      else
      begin
         timer_irq_o <= flag_q & mask_q;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Clock output to the shared port.

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         shared_output_port_o    <= 1'b0;
         shared_output_port_oe_o <= 1'b0;
      end
      else
      begin
         shared_output_port_o    <= cout_q & sel_level;
         shared_output_port_oe_o <= cout_q;
      end
   end

endmodule
